/* File: include/pic_pkg.sv */
// Purpose: constants for the priority interrupt controller
// Assumes: 32-bit APB, byte addresses, word registers
// Notes:   source 0 is nmi, 1..5 irq lines, 6..26 peripherals
package pic_pkg;
    localparam int N_IRQ = 5;
    localparam int N_PER = 21;
    localparam int N_SRC = 1 + N_IRQ + N_PER;
    // register byte offsets
    localparam logic [7:0] OFS_SYS  = 8'h00;
    localparam logic [7:0] OFS_CCR  = 8'h04;
    localparam logic [7:0] OFS_PRA  = 8'h08;
    localparam logic [7:0] OFS_PRB  = 8'h0C;
    localparam logic [7:0] OFS_IEN  = 8'h10;
    localparam logic [7:0] OFS_PEN  = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    // field positions
    localparam int SYS_UE  = 0;
    localparam int SYS_ADV = 1;
    localparam int CCR_I   = 7;
    localparam int CCR_UI  = 6;
    // reset values
    localparam logic       RST_UE  = 1'b1;
    localparam logic       RST_ADV = 1'b1;
    localparam logic       RST_I   = 1'b1;
    localparam logic       RST_UI  = 1'b0;
    localparam logic [7:0] RST_PR  = 8'h00;
    // phase lengths in states
    localparam logic [3:0] T_ONCHIP = 4'h4;
    localparam logic [3:0] T_EXT2   = 4'h8;
    localparam logic [3:0] T_EXT3   = 4'hC;
    localparam logic [3:0] T_INTERN = 4'h4;
    // memory kinds
    localparam logic [1:0] MEM_ON   = 2'h0;
    localparam logic [1:0] MEM_EXT2 = 2'h1;
    localparam logic [1:0] MEM_EXT3 = 2'h2;
    // vector number per source, highest first
    localparam logic [5:0] VEC_NUM [N_SRC] = '{
        6'h07, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
        6'h10, 6'h14, 6'h18, 6'h19, 6'h1A,
        6'h1C, 6'h1D, 6'h1E, 6'h20, 6'h21,
        6'h22, 6'h24, 6'h25, 6'h26, 6'h28,
        6'h29, 6'h2A, 6'h34, 6'h35, 6'h36,
        6'h37, 6'h3C};
    // bit of {pra, prb} that sets each source's level
    localparam logic [3:0] PRI_BIT [N_SRC] = '{
        4'h0, 4'hF, 4'hE, 4'hD, 4'hD,
        4'hC, 4'hB, 4'hA, 4'hA, 4'hA,
        4'h9, 4'h9, 4'h9, 4'h8, 4'h8,
        4'h8, 4'h7, 4'h7, 4'h7, 4'h6,
        4'h6, 4'h6, 4'h3, 4'h3, 4'h3,
        4'h3, 4'h1};
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_STCK = 3'h1,
        ST_VECT = 3'h3,
        ST_PREF = 3'h2,
        ST_INTP = 3'h6
    } pic_state_t;
endpackage

/* File: verilog/pic_ctrl.sv */
// Purpose: interrupt arbitration, masking and exception sequencing
// Assumes: core pulses instr_done at each instruction end
// Notes:   registers reached over APB, zero wait states
`timescale 1ns/100ps
module pic_ctrl
    import pic_pkg::*;
#(
    parameter int PC_W = 24
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // request pins and sources
    input  wire logic              nmi_pin,
    input  wire logic [N_IRQ-1:0]  irq_pin,
    input  wire logic [N_PER-1:0]  per_req,
    input  wire logic              hw_standby,
    // core status
    input  wire logic              instr_done,
    input  wire logic              ctrl_instr,
    input  wire logic              bmove_byte,
    input  wire logic              bmove_word,
    input  wire logic              xfer_edge,
    input  wire logic [PC_W-1:0]   next_pc,
    input  wire logic [1:0]        mem_kind,
    input  wire logic              wait_req,
    input  wire logic [31:0]       vec_data,
    // exception sequence outputs
    output logic                   exc_busy,
    output pic_state_t             exc_state,
    output logic                   stack_push,
    output logic [PC_W-1:0]        stack_pc_r,
    output logic [7:0]             stack_ccr_r,
    output logic                   vec_fetch,
    output logic [15:0]            vec_addr_r,
    output logic [5:0]             vec_num_r,
    output logic [31:0]            handler_r,
    output logic                   svc_start_r,
    output logic                   mask_flag,
    output logic                   sec_mask_flag
);
    import pic_pkg::*;

    initial begin
        if (PC_W < 16 || PC_W > 32) begin
            $error("pic_ctrl: PC_W must be 16 to 32");
        end
    end

    pic_state_t        state_r;
    pic_state_t        state_nxt;
    logic              scheme_r;
    logic              adv_r;
    logic              mask_i_r;
    logic              mask_ui_r;
    logic [7:0]        pra_r;
    logic [7:0]        prb_r;
    logic [N_IRQ-1:0]  ien_r;
    logic [N_PER-1:0]  pen_r;
    logic [N_IRQ-1:0]  ien_eff_r;
    logic [N_PER-1:0]  pen_eff_r;
    logic [2:0]        nmi_sy_r;
    logic [N_IRQ-1:0]  irq_s1_r;
    logic [N_IRQ-1:0]  irq_s2_r;
    logic [N_IRQ-1:0]  irq_d_r;
    logic              nmi_pend_r;
    logic              inhibit_r;
    logic              sel_vld_r;
    logic [4:0]        sel_idx_r;
    logic [3:0]        cnt_r;
    logic [N_SRC-1:0]  req;
    logic [N_SRC-1:0]  lvl;
    logic [N_SRC-1:0]  open_m;
    logic [15:0]       pri_w;
    logic              hit1;
    logic              hit0;
    logic [4:0]        idx1;
    logic [4:0]        idx0;
    logic              sel_vld;
    logic [4:0]        sel_idx;
    logic              take_nmi;
    logic              take_msk;
    logic              accept;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;
    logic [3:0]        plen;
    logic              ext_mem;
    logic              last;
    logic [5:0]        acc_vec;

    // pins cross in through two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_sy_r <= 3'h0;
            irq_s1_r <= '0;
            irq_s2_r <= '0;
            irq_d_r  <= '0;
        end else begin
            nmi_sy_r <= {nmi_sy_r[1:0], nmi_pin};
            irq_s1_r <= irq_pin;
            irq_s2_r <= irq_s1_r;
            irq_d_r  <= irq_s2_r & ien_eff_r;
        end
    end

    // nmi is edge latched; a new edge beats the clear on acceptance, standby clears over both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_pend_r <= 1'b0;
        end else if (hw_standby) begin
            nmi_pend_r <= 1'b0;
        end else if (nmi_sy_r[1] && !nmi_sy_r[2]) begin
            nmi_pend_r <= 1'b1;
        end else if (accept && sel_idx_r == 5'h00) begin
            nmi_pend_r <= 1'b0;
        end
    end

    // enables only change at an instruction end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_eff_r <= '0;
            pen_eff_r <= '0;
        end else if (instr_done) begin
            ien_eff_r <= ien_r;
            pen_eff_r <= pen_r;
        end
    end

    assign pri_w = {pra_r, prb_r};

    // per source request, level and mask
    generate
        for (genvar i = 0; i < N_SRC; i++) begin : g_src
            if (i == 0) begin : g_nmi
                assign req[i] = nmi_pend_r;
            end else if (i <= N_IRQ) begin : g_irq
                assign req[i] = irq_d_r[i-1];
            end else begin : g_per
                assign req[i] = per_req[i-1-N_IRQ]
                              & pen_eff_r[i-1-N_IRQ];
            end
            assign lvl[i] = pri_w[PRI_BIT[i]];
            assign open_m[i] = lvl[i]
                ? !(mask_i_r && (scheme_r || mask_ui_r))
                : !mask_i_r;
        end
    endgenerate

    // lowest index wins within a level
    always_comb begin
        hit1 = 1'b0;
        hit0 = 1'b0;
        idx1 = 5'h00;
        idx0 = 5'h00;
        for (int i = N_SRC - 1; i >= 1; i--) begin
            if (req[i] && open_m[i] && lvl[i]) begin
                hit1 = 1'b1;
                idx1 = 5'(i);
            end
            if (req[i] && open_m[i] && !lvl[i]) begin
                hit0 = 1'b1;
                idx0 = 5'(i);
            end
        end
        if (req[0]) begin
            sel_vld = 1'b1;
            sel_idx = 5'h00;
        end else if (hit1) begin
            sel_vld = 1'b1;
            sel_idx = idx1;
        end else begin
            sel_vld = hit0;
            sel_idx = idx0;
        end
    end

    // decision takes one state; pins gained one more above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_vld_r <= 1'b0;
            sel_idx_r <= 5'h00;
        end else begin
            sel_vld_r <= sel_vld;
            sel_idx_r <= sel_idx;
        end
    end

    // flag, read in STAT, that the last finished instruction was a control instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_r <= 1'b0;
        end else if (instr_done) begin
            inhibit_r <= ctrl_instr;
        end
    end

    // the end of a control instruction is never a boundary: the next
    // instruction must run first, so nothing is taken there
    assign take_nmi = !hw_standby && !bmove_byte
        && !(instr_done && ctrl_instr)
        && ((instr_done && !bmove_word)
            || (bmove_word && xfer_edge));
    assign take_msk = instr_done && !ctrl_instr
        && !bmove_byte && !bmove_word;
    assign accept = state_r == ST_IDLE && sel_vld_r
        && (sel_idx_r == 5'h00 ? take_nmi : take_msk);

    // phase length by memory kind
    always_comb begin
        case (mem_kind)
            MEM_ON:   plen = T_ONCHIP;
            MEM_EXT2: plen = T_EXT2;
            MEM_EXT3: plen = T_EXT3;
            default:  plen = T_EXT3;
        endcase
    end

    assign ext_mem = mem_kind != MEM_ON;
    // a wait state holds the count where memory is external, except in ST_INTP
    assign last = !(ext_mem && wait_req && state_r != ST_INTP)
        && (state_r == ST_INTP ? cnt_r == T_INTERN - 4'h1
                               : cnt_r == plen - 4'h1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (accept) state_nxt = ST_STCK;
            ST_STCK: if (last) state_nxt = ST_VECT;
            ST_VECT: if (last) state_nxt = ST_PREF;
            ST_PREF: if (last) state_nxt = ST_INTP;
            ST_INTP: if (last) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (state_r == ST_IDLE || last) begin
            cnt_r <= 4'h0;
        end else if (!(ext_mem && wait_req)
                     || state_r == ST_INTP) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign acc_vec = VEC_NUM[sel_idx_r];

    // context and vector captured at acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pc_r  <= '0;
            stack_ccr_r <= 8'h00;
            vec_num_r   <= 6'h00;
            vec_addr_r  <= 16'h0000;
        end else if (accept) begin
            stack_pc_r  <= next_pc;
            stack_ccr_r <= {mask_i_r, mask_ui_r, 6'h00};
            vec_num_r   <= acc_vec;
            vec_addr_r  <= adv_r ? {8'h00, acc_vec, 2'h0}
                                 : {9'h000, acc_vec, 1'h0};
        end
    end

    // handler address read at the end of vector fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handler_r   <= 32'h0000_0000;
            svc_start_r <= 1'b0;
        end else begin
            if (state_r == ST_VECT && last) begin
                handler_r <= adv_r ? vec_data
                    : {16'h0000, vec_data[15:0]};
            end
            svc_start_r <= state_r == ST_INTP && last;
        end
    end

    assign exc_busy   = state_r != ST_IDLE;
    assign exc_state  = state_r;
    assign stack_push = state_r == ST_STCK;
    assign vec_fetch  = state_r == ST_VECT;
    assign mask_flag     = mask_i_r;
    assign sec_mask_flag = mask_ui_r;

    // apb: zero wait, read data latched in setup
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign mapped = paddr == OFS_SYS || paddr == OFS_CCR
                 || paddr == OFS_PRA || paddr == OFS_PRB
                 || paddr == OFS_IEN || paddr == OFS_PEN
                 || paddr == OFS_STAT;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scheme_r <= RST_UE;
            adv_r    <= RST_ADV;
        end else if (wr_en && paddr == OFS_SYS) begin
            scheme_r <= pwdata[SYS_UE];
            adv_r    <= pwdata[SYS_ADV];
        end
    end

    // stacking sets I, and UI too when scheme_r is low; it beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_i_r  <= RST_I;
            mask_ui_r <= RST_UI;
        end else if (state_r == ST_STCK && last) begin
            mask_i_r <= 1'b1;
            if (!scheme_r) begin
                mask_ui_r <= 1'b1;
            end
        end else if (wr_en && paddr == OFS_CCR) begin
            mask_i_r  <= pwdata[CCR_I];
            mask_ui_r <= pwdata[CCR_UI];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pra_r <= RST_PR;
            prb_r <= RST_PR;
        end else if (wr_en) begin
            if (paddr == OFS_PRA) begin
                pra_r <= pwdata[7:0];
            end
            if (paddr == OFS_PRB) begin
                prb_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_r <= '0;
            pen_r <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_IEN) begin
                ien_r <= pwdata[N_IRQ-1:0];
            end
            if (paddr == OFS_PEN) begin
                pen_r <= pwdata[N_PER-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                OFS_SYS: prdata <= {30'h0, adv_r, scheme_r};
                OFS_CCR: prdata <= {24'h0, mask_i_r,
                                    mask_ui_r, 6'h00};
                OFS_PRA: prdata <= {24'h0, pra_r};
                OFS_PRB: prdata <= {24'h0, prb_r};
                OFS_IEN: prdata <= {27'h0, ien_r};
                OFS_PEN: prdata <= {11'h0, pen_r};
                OFS_STAT: prdata <= {16'h0, inhibit_r,
                    nmi_pend_r, sel_vld_r, state_r,
                    4'h0, vec_num_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* File: verif/pic_core_model.sv */
// Purpose: behavioural core and vector memory facing the controller
// Assumes: one instruction ends every fourth cycle outside exception sequences, vectors on-chip
// Notes:   vector bus shows inverted junk outside fetch cycles
`timescale 1ns/100ps
module pic_core_model #(
    parameter int PC_W = 24
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // controller status
    input  wire logic            exc_busy,
    input  wire logic            vec_fetch,
    input  wire logic [15:0]     vec_addr_r,
    input  wire logic            bmove_word,
    // core outputs
    output logic                 instr_done,
    output logic                 xfer_edge,
    output logic [PC_W-1:0]      next_pc,
    output logic [31:0]          vec_data
);
    logic [1:0] cnt_r;
    // no instruction ends while the exception sequence owns the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r      <= 2'h0;
            instr_done <= 1'b0;
            xfer_edge  <= 1'b0;
            next_pc    <= PC_W'(32'h100);
            vec_data   <= 32'h0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            instr_done <= !exc_busy && cnt_r == 2'h3;
            xfer_edge  <= bmove_word && cnt_r[0];
            if (instr_done)
                next_pc <= next_pc + PC_W'(32'h2);
            vec_data   <= vec_fetch ? {16'h5A00, vec_addr_r} : ~vec_data;
        end
    end
endmodule

/* File: verif/pic_ctrl_chk.sv */
// Purpose: port-level checks of the exception sequencer
// Assumes: stacking and fetch length checks only for on-chip memory kind
// Notes:   bound into every pic_ctrl instance
`timescale 1ns/100ps
module pic_ctrl_chk
    import pic_pkg::*;
#(
    parameter int PC_W = 24
) (
    // clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // core status
    input wire logic            instr_done,
    input wire logic            ctrl_instr,
    input wire logic            bmove_byte,
    input wire logic            xfer_edge,
    input wire logic [PC_W-1:0] next_pc,
    input wire logic [1:0]      mem_kind,
    // sequence outputs
    input wire logic            exc_busy,
    input wire pic_state_t      exc_state,
    input wire logic            stack_push,
    input wire logic            vec_fetch,
    input wire logic [PC_W-1:0] stack_pc_r,
    input wire logic [15:0]     vec_addr_r,
    input wire logic [5:0]      vec_num_r,
    input wire logic            svc_start_r,
    input wire logic            mask_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_stack_len: assert property ($rose(stack_push) && mem_kind == 2'h0
        |-> stack_push [*4] ##1 vec_fetch) else $error("stacking length");
    a_fetch_len: assert property ($rose(vec_fetch) && mem_kind == 2'h0
        |-> vec_fetch [*4] ##1 (exc_state == ST_PREF && !vec_fetch))
        else $error("vector fetch length");
    a_intp_len: assert property (exc_state == ST_PREF ##1 exc_state == ST_INTP
        |-> (exc_state == ST_INTP) [*4] ##1 (exc_state == ST_IDLE && svc_start_r))
        else $error("internal phase length");
    a_flags_set: assert property ($fell(stack_push) && exc_busy
        |-> mask_flag) else $error("mask flag not set");
    a_accept_edge: assert property ($rose(exc_busy)
        |-> $past(instr_done) || $past(xfer_edge)) else $error("mid accept");
    a_byte_hold: assert property (bmove_byte && !exc_busy
        |=> !exc_busy) else $error("accept in byte move");
    a_ctrl_shield: assert property (instr_done && ctrl_instr && !exc_busy
        |=> !exc_busy) else $error("accept after control instr");
    a_vec_addr: assert property ($rose(exc_busy) |->
        vec_addr_r == {8'h00, vec_num_r, 2'h0} ||
        vec_addr_r == {9'h000, vec_num_r, 1'h0}) else $error("vector addr");
    a_stack_pc: assert property ($rose(exc_busy)
        |-> stack_pc_r == $past(next_pc)) else $error("stacked pc");
endmodule
bind pic_ctrl pic_ctrl_chk #(.PC_W(PC_W)) pic_ctrl_chk_i (.pclk(pclk),
    .presetn(presetn), .instr_done(instr_done), .ctrl_instr(ctrl_instr),
    .bmove_byte(bmove_byte), .xfer_edge(xfer_edge), .next_pc(next_pc),
    .mem_kind(mem_kind), .exc_busy(exc_busy), .exc_state(exc_state),
    .stack_push(stack_push), .vec_fetch(vec_fetch), .stack_pc_r(stack_pc_r),
    .vec_addr_r(vec_addr_r), .vec_num_r(vec_num_r),
    .svc_start_r(svc_start_r), .mask_flag(mask_flag));

/* File: verif/pic_ctrl_tb.sv */
// Purpose: self-checking bench for the interrupt controller
// Assumes: no wait states, standby never entered
// Notes:   sequencer outputs sampled on the falling edge, where they are settled; APB read data on a rising edge
`timescale 1ns/100ps
module pic_ctrl_tb;
    import pic_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, adv;
    logic nmi_pin, hw_standby, instr_done, ctrl_instr, bmove_byte;
    logic bmove_word, xfer_edge, wait_req, exc_busy, stack_push, vec_fetch;
    logic svc_start_r, mask_flag, sec_mask_flag;
    logic [7:0]  paddr, stack_ccr_r;
    logic [31:0] pwdata, prdata, vec_data, handler_r, d, seed, cseed;
    logic [4:0]  irq_pin;
    logic [20:0] per_req;
    logic [23:0] next_pc, stack_pc_r;
    logic [15:0] vec_addr_r;
    logic [5:0]  vec_num_r;
    logic [1:0]  mem_kind;
    pic_state_t  exc_state;
    int          n_fail, samples_checked, k, k2;
    pic_ctrl pic_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .nmi_pin, .irq_pin, .per_req,
        .hw_standby, .instr_done, .ctrl_instr, .bmove_byte, .bmove_word,
        .xfer_edge, .next_pc, .mem_kind, .wait_req, .vec_data, .exc_busy,
        .exc_state, .stack_push, .stack_pc_r, .stack_ccr_r, .vec_fetch,
        .vec_addr_r, .vec_num_r, .handler_r, .svc_start_r, .mask_flag,
        .sec_mask_flag);
    pic_core_model pic_core_model_i (.pclk, .presetn, .exc_busy, .vec_fetch,
        .vec_addr_r, .bmove_word, .instr_done, .xfer_edge, .next_pc,
        .vec_data);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang;
        chk(32'h0, 32'h1);
        finish_test;
    endtask
    // apb master: request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hang;
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle_chk(input int n);
        logic b;
        b = 1'b0;
        repeat (n) begin
            @(negedge pclk);
            if (exc_busy !== 1'b0)
                b = 1'b1;
        end
        chk(b, 32'h0);
    endtask
    task automatic nmi_pulse;
        @(posedge pclk);
        nmi_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        nmi_pin <= 1'b0;
    endtask
    // waits for one whole exception sequence and checks its results
    task automatic run_exc(input logic [5:0] v, input logic av,
                           input logic [1:0] m);
        int n;
        logic [15:0] a;
        a = av ? {8'h00, v, 2'h0} : {9'h000, v, 1'h0};
        n = 0;
        while (exc_busy !== 1'b1) begin
            @(negedge pclk);
            n++;
            if (n > 400) hang;
        end
        n = 0;
        while (exc_busy === 1'b1) begin
            @(negedge pclk);
            n++;
            if (n > 100) hang;
        end
        chk(n, 3 * (4 + 4 * m) + 4);
        chk(vec_num_r, v);
        chk(vec_addr_r, a);
        chk(handler_r[15:0], a);
        chk(svc_start_r, 32'h1);
        $display("exception vector %0d done", v);
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // random control-register instructions exercise the shielding logic
    always @(posedge pclk) begin
        cseed <= lfsr(cseed);
        ctrl_instr <= cseed[2] & cseed[5];
    end
    initial begin
        {presetn, psel, penable, pwrite, nmi_pin, hw_standby, ctrl_instr} = 0;
        {bmove_byte, bmove_word, wait_req, paddr, pwdata, irq_pin} = 0;
        {per_req, mem_kind, n_fail, samples_checked} = 0;
        seed = 32'h000167BB;
        cseed = 32'h000167BB;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_SYS, 0);
        chk(d, 32'h3);
        apb(0, OFS_CCR, 0);
        chk(d, 32'h80);
        apb(0, 8'h1C, 0);
        chk({e, d[30:0]}, 32'h80000000);
        apb(1, OFS_IEN, 32'h1F);
        apb(1, OFS_PEN, 32'h1FFFFF);
        irq_pin <= 5'h01;
        idle_chk(60);
        nmi_pulse;
        run_exc(6'h07, 1, 0);
        chk(mask_flag, 32'h1);
        chk(stack_ccr_r, 32'h80);
        apb(1, OFS_CCR, 0);
        run_exc(6'h0C, 1, 0);
        chk(stack_ccr_r, 32'h0);
        $display("test scheme one done");
        apb(1, OFS_SYS, 32'h2);
        apb(1, OFS_PRA, 32'h20);
        apb(1, OFS_CCR, 32'h80);
        irq_pin <= 5'h05;
        run_exc(6'h0E, 1, 0);
        chk({mask_flag, sec_mask_flag}, 32'h3);
        idle_chk(60);
        irq_pin <= 5'h01;
        apb(1, OFS_CCR, 32'h80);
        idle_chk(60);
        apb(1, OFS_CCR, 0);
        run_exc(6'h0C, 1, 0);
        irq_pin <= 5'h02;
        apb(1, OFS_IEN, 32'h1D);
        apb(1, OFS_CCR, 0);
        idle_chk(60);
        irq_pin <= 5'h00;
        $display("test scheme zero done");
        bmove_byte <= 1'b1;
        nmi_pulse;
        idle_chk(60);
        bmove_byte <= 1'b0;
        run_exc(6'h07, 1, 0);
        bmove_word <= 1'b1;
        nmi_pulse;
        run_exc(6'h07, 1, 0);
        bmove_word <= 1'b0;
        $display("test block move done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            k = seed[4:0] % 21;
            k2 = seed[12:8] % 21;
            adv = seed[20];
            if (i == 0) begin
                {k, k2} = {32'd20, 32'd20};
            end
            mem_kind <= (i == 0) ? 2'h2 : 2'(seed[17:16] % 3);
            apb(1, OFS_SYS, {30'h0, adv, 1'b1});
            apb(1, OFS_CCR, 0);
            per_req <= (21'h1 << k) | (21'h1 << k2);
            run_exc(VEC_NUM[6 + ((k < k2) ? k : k2)], adv, mem_kind);
            per_req <= 21'h0;
        end
        $display("test random peripherals done");
        finish_test;
    end
endmodule
